// File: src/adc_dispatch_pkg.sv
// Constants, field layouts and carrier types for the sample dispatcher.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
//
// What this block does
// RULE1: Each rising trigger edge converts the next input pin in turn; the code holds at most one pending edge and drops the rest.
// RULE2: Each conversion yields a 12-bit result for the sampled pin.
// RULE3: Results go to the endpoint programmed for that pin when enabled.
// RULE4: Registers answer as peripheral 2 with 32-bit reads and writes.
// RULE5: Pin registers sit at 0x00 to 0x0c, general control at 0x20.
// RULE6: Pin register bits 31:8 hold the destination, reset to zero.
// RULE7: Pin register bit 0 enables the pin and resets to zero.
// RULE8: Pin register bits 7:1 are reserved and read-only.
// RULE9: Reserved bits read zero and writes to them change nothing.
package adc_dispatch_pkg;

    // ****************************************************************
    // Addressing
    // ****************************************************************
    localparam logic [7:0] PERIPH_ID     = 8'h02;
    localparam logic [7:0] PIN0_OFS      = 8'h00;
    localparam logic [7:0] PIN1_OFS      = 8'h04;
    localparam logic [7:0] PIN2_OFS      = 8'h08;
    localparam logic [7:0] PIN3_OFS      = 8'h0c;
    localparam logic [7:0] GEN_CTL_OFS   = 8'h20;
    localparam logic [7:0] STATUS_OFS    = 8'h24;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int         DEST_LSB      = 8;
    localparam int         PIN_EN_BIT    = 0;
    localparam int         GEN_EN_BIT    = 0;
    localparam int         ST_BUSY_BIT   = 0;
    localparam int         ST_PEND_BIT   = 1;
    localparam int         ST_FULL_BIT   = 2;
    localparam int         ST_CUR_LSB    = 4;
    localparam logic [31:0] PIN_CTL_RST  = 32'h0000_0000;
    localparam logic [31:0] GEN_CTL_RST  = 32'h0000_0000;
    localparam int         PIN_COUNT     = 4;
    localparam int         RESULT_W      = 12;
    localparam int         FIFO_DEPTH    = 16;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  periph;
        logic [7:0]  regnum;
        logic [31:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic        done;
        logic        ok;
        logic [31:0] rdata;
    } acc_resp_t;

    typedef struct packed {
        logic [23:0]         dest;
        logic [1:0]          pin;
        logic [RESULT_W-1:0] result;
    } sample_msg_t;

    typedef struct packed {
        logic [23:0] dest;
        logic        en;
    } pin_ctl_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT, SEQ_PUSH} seq_state_t;

    localparam int         MSG_W         = $bits(sample_msg_t);

endpackage : adc_dispatch_pkg

// File: src/sample_fifo.sv
// First-in first-out buffer with a registered head word.
// Assumes power-of-two depth and the clock enable of the parent block.
module sample_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 16
) (
    // Clock, reset and enable
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             ce_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    // The head register is refilled from memory whenever memory holds a word and the head is empty or being taken.
    always_comb begin
        in_ready_out   = (count != FULL_COUNT);
        push           = in_valid_in && in_ready_out;
        pop            = (count != '0) && (!out_valid_out || out_ready_in);
        next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count     = count + (PW+1)'(push) - (PW+1)'(pop);
        next_out_valid = pop || (out_valid_out && !out_ready_in);
        next_out_data  = pop ? mem[rd_ptr] : out_data_out;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr        <= '0;
            rd_ptr        <= '0;
            count         <= '0;
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else if (ce_in) begin
            wr_ptr        <= next_wr_ptr;
            rd_ptr        <= next_rd_ptr;
            count         <= next_count;
            out_valid_out <= next_out_valid;
            out_data_out  <= next_out_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && push && !sys_rst_in) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

endmodule : sample_fifo

// File: src/adc_sample_dispatch.sv
// Trigger sequencing, pin registers and result dispatch for the converter.
// Assumes the converter core answers on the same clock with a done pulse.
module adc_sample_dispatch (
    // Clock, reset and enable
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          ce_in,
    // Sampling trigger pin
    input  wire logic                          sample_trig_in,
    // Peripheral register access
    input  wire adc_dispatch_pkg::acc_req_t    acc_req_in,
    output adc_dispatch_pkg::acc_resp_t        acc_resp_out,
    // Converter core
    output logic                               conv_start_out,
    output logic [1:0]                         conv_pin_out,
    input  wire logic                          conv_done_in,
    input  wire logic [11:0]                   conv_result_in,
    // Message endpoint
    output logic                               msg_valid_out,
    input  wire logic                          msg_ready_in,
    output adc_dispatch_pkg::sample_msg_t      msg_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Forms the read word of a pin register; bits 7:1 are always zero.
    function automatic logic [31:0] pin_word(
        input adc_dispatch_pkg::pin_ctl_t c
    );
        logic [31:0] w;
        w = '0;
        w[31:adc_dispatch_pkg::DEST_LSB] = c.dest;
        w[adc_dispatch_pkg::PIN_EN_BIT]  = c.en;
        return w;
    endfunction : pin_word

    // Finds the first enabled pin at or after the cursor, with a found bit.
    function automatic logic [2:0] pick_next(
        input logic [3:0] en,
        input logic [1:0] from
    );
        logic [2:0] r;
        logic [1:0] p;
        r = '0;
        for (int i = 3; i >= 0; i--) begin
            p = from + 2'(i);
            if (en[p]) begin
                r = {1'b1, p};
            end
        end
        return r;
    endfunction : pick_next

    // ****************************************************************
    // Trigger synchroniser
    // ****************************************************************
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_edge;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else if (ce_in) begin
            trig_s1 <= sample_trig_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    assign trig_edge = trig_s2 && !trig_s3; // [RULE1]

    // ****************************************************************
    // Registers
    // ****************************************************************
    adc_dispatch_pkg::pin_ctl_t  pin_ctl [adc_dispatch_pkg::PIN_COUNT];
    adc_dispatch_pkg::pin_ctl_t  next_pin_ctl [adc_dispatch_pkg::PIN_COUNT];
    logic [31:0]                 gen_ctl;
    logic [31:0]                 next_gen_ctl;
    adc_dispatch_pkg::acc_resp_t next_resp;
    logic                        acc_hit;
    logic                        pin_hit;
    logic [1:0]                  acc_pin;
    logic [31:0]                 status_word;
    logic [3:0]                  en_vec;
    logic                        fifo_in_ready;

    always_comb begin
        acc_hit = acc_req_in.valid
               && acc_req_in.periph == adc_dispatch_pkg::PERIPH_ID; // [RULE4]
        pin_hit = acc_req_in.regnum[7:4] == 4'h0
               && acc_req_in.regnum[1:0] == 2'h0; // [RULE5]
        acc_pin = acc_req_in.regnum[3:2];
        for (int i = 0; i < adc_dispatch_pkg::PIN_COUNT; i++) begin
            en_vec[i] = pin_ctl[i].en;
        end
        next_pin_ctl = pin_ctl;
        next_gen_ctl = gen_ctl;
        next_resp    = '0;
        if (acc_hit) begin
            next_resp.done = 1'b1;
            next_resp.ok   = 1'b1;
            if (pin_hit) begin
                next_resp.rdata = pin_word(pin_ctl[acc_pin]); // [RULE9]
                if (acc_req_in.write) begin
                    // Only the destination and enable bit are stored.
                    next_pin_ctl[acc_pin].dest =
                        acc_req_in.wdata[31:adc_dispatch_pkg::DEST_LSB];
                    next_pin_ctl[acc_pin].en =
                        acc_req_in.wdata[adc_dispatch_pkg::PIN_EN_BIT];
                end // [RULE6] [RULE7] [RULE8]
            end else if (acc_req_in.regnum
                         == adc_dispatch_pkg::GEN_CTL_OFS) begin
                next_resp.rdata = gen_ctl; // [RULE5]
                if (acc_req_in.write) begin
                    next_gen_ctl = acc_req_in.wdata;
                end
            end else if (acc_req_in.regnum
                         == adc_dispatch_pkg::STATUS_OFS) begin
                next_resp.rdata = status_word;
            end else begin
                next_resp.ok = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < adc_dispatch_pkg::PIN_COUNT; i++) begin
                pin_ctl[i].dest <=
                    adc_dispatch_pkg::PIN_CTL_RST[31:8]; // [RULE6]
                pin_ctl[i].en   <=
                    adc_dispatch_pkg::PIN_CTL_RST[0]; // [RULE7]
            end
            gen_ctl      <= adc_dispatch_pkg::GEN_CTL_RST;
            acc_resp_out <= '0;
        end else if (ce_in) begin
            pin_ctl      <= next_pin_ctl;
            gen_ctl      <= next_gen_ctl;
            acc_resp_out <= next_resp;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    adc_dispatch_pkg::seq_state_t  state;
    adc_dispatch_pkg::seq_state_t  next_state;
    adc_dispatch_pkg::sample_msg_t word;
    adc_dispatch_pkg::sample_msg_t next_word;
    logic                          pending;
    logic                          next_pending;
    logic                          clear_pending;
    logic [1:0]                    cursor;
    logic [1:0]                    next_cursor;
    logic                          next_start;
    logic [1:0]                    next_conv_pin;
    logic [2:0]                    pick;

    always_comb begin
        pick          = pick_next(en_vec, cursor);
        next_state    = state;
        next_word     = word;
        next_cursor   = cursor;
        next_start    = 1'b0;
        next_conv_pin = conv_pin_out;
        clear_pending = 1'b0;
        unique case (state)
            adc_dispatch_pkg::SEQ_IDLE: begin
                if (pending) begin
                    clear_pending = 1'b1;
                    if (gen_ctl[adc_dispatch_pkg::GEN_EN_BIT] && pick[2]) begin
                        next_start     = 1'b1; // [RULE1]
                        next_conv_pin  = pick[1:0];
                        next_cursor    = pick[1:0] + 2'h1;
                        next_word.pin  = pick[1:0];
                        next_word.dest = pin_ctl[pick[1:0]].dest; // [RULE3]
                        next_state     = adc_dispatch_pkg::SEQ_CONVERT;
                    end
                end
            end
            adc_dispatch_pkg::SEQ_CONVERT: begin
                if (conv_done_in) begin
                    next_word.result = conv_result_in; // [RULE2]
                    next_state       = adc_dispatch_pkg::SEQ_PUSH;
                end
            end
            adc_dispatch_pkg::SEQ_PUSH: begin
                // A full buffer holds the sequencer here.
                if (fifo_in_ready) begin
                    next_state = adc_dispatch_pkg::SEQ_IDLE;
                end
            end
        endcase
        // A trigger edge in the cycle that consumes the last one is kept.
        next_pending = (pending && !clear_pending) || trig_edge;
        status_word = '0;
        status_word[adc_dispatch_pkg::ST_BUSY_BIT] =
            state != adc_dispatch_pkg::SEQ_IDLE;
        status_word[adc_dispatch_pkg::ST_PEND_BIT] = pending;
        status_word[adc_dispatch_pkg::ST_FULL_BIT] = !fifo_in_ready;
        status_word[adc_dispatch_pkg::ST_CUR_LSB +: 2] = cursor;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state          <= adc_dispatch_pkg::SEQ_IDLE;
            word           <= '0;
            pending        <= 1'b0;
            cursor         <= '0;
            conv_start_out <= 1'b0;
            conv_pin_out   <= '0;
        end else if (ce_in) begin
            state          <= next_state;
            word           <= next_word;
            pending        <= next_pending;
            cursor         <= next_cursor;
            conv_start_out <= next_start;
            conv_pin_out   <= next_conv_pin;
        end
    end

    // ****************************************************************
    // Result buffer
    // ****************************************************************
    sample_fifo #(
        .WIDTH (adc_dispatch_pkg::MSG_W),
        .DEPTH (adc_dispatch_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .in_valid_in   (state == adc_dispatch_pkg::SEQ_PUSH),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (word),
        .out_valid_out (msg_valid_out),
        .out_ready_in  (msg_ready_in),
        .out_data_out  (msg_out)
    ); // [RULE3]

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_edge_idle;
        trig_edge && ce_in && state == adc_dispatch_pkg::SEQ_IDLE
        && !pending && gen_ctl[adc_dispatch_pkg::GEN_EN_BIT] && en_vec != '0;
    endsequence

    sequence s_done_taken;
        state == adc_dispatch_pkg::SEQ_CONVERT && conv_done_in && ce_in;
    endsequence

    AST_TRIG_STARTS: assert property ( // [RULE1]
        @(posedge clk_in) disable iff (sys_rst_in)
        s_edge_idle ##1 ce_in |=> conv_start_out
    ) else $error("Trigger edge did not start a conversion.");

    AST_START_PULSE: assert property ( // [RULE1]
        @(posedge clk_in) disable iff (sys_rst_in)
        conv_start_out && ce_in |=> !conv_start_out
    ) else $error("Conversion start lasted more than one cycle.");

    AST_PIN_ENABLED: assert property ( // [RULE7]
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(conv_start_out) |-> $past(en_vec[pick[1:0]]) && $past(pick[2])
    ) else $error("Conversion started on a disabled pin.");

    AST_RESULT_KEPT: assert property ( // [RULE2]
        @(posedge clk_in) disable iff (sys_rst_in)
        s_done_taken |=> word.result == $past(conv_result_in)
            && state == adc_dispatch_pkg::SEQ_PUSH
    ) else $error("Conversion result was not captured.");

    AST_DEST_MATCH: assert property ( // [RULE3]
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(conv_start_out) |-> word.dest == $past(pin_ctl[pick[1:0]].dest)
            && word.pin == conv_pin_out
    ) else $error("Message destination differs from the pin register.");

    AST_OTHER_PERIPH: assert property ( // [RULE4]
        @(posedge clk_in) disable iff (sys_rst_in)
        acc_req_in.valid && ce_in
        && acc_req_in.periph != adc_dispatch_pkg::PERIPH_ID
        |=> !acc_resp_out.done
    ) else $error("Answered an access for another peripheral.");

    AST_UNMAPPED_FAIL: assert property ( // [RULE5]
        @(posedge clk_in) disable iff (sys_rst_in)
        acc_hit && ce_in && !pin_hit
        && acc_req_in.regnum != adc_dispatch_pkg::GEN_CTL_OFS
        && acc_req_in.regnum != adc_dispatch_pkg::STATUS_OFS
        |=> acc_resp_out.done && !acc_resp_out.ok
    ) else $error("Unmapped register did not answer with failure.");

    AST_RESERVED_ZERO: assert property ( // [RULE8]
        @(posedge clk_in) disable iff (sys_rst_in)
        acc_hit && ce_in && pin_hit |=> acc_resp_out.rdata[7:1] == 7'h00
    ) else $error("Reserved pin register bits read nonzero.");

    AST_PIN_WRITE: assert property ( // [RULE6]
        @(posedge clk_in) disable iff (sys_rst_in)
        acc_hit && ce_in && acc_req_in.write
        && acc_req_in.regnum == adc_dispatch_pkg::PIN0_OFS
        |=> pin_ctl[0].dest == $past(acc_req_in.wdata[31:8])
            && pin_ctl[0].en == $past(acc_req_in.wdata[0])
    ) else $error("Pin register write was not stored.");

endmodule : adc_sample_dispatch

// File: test/endpoint_model.sv
// Message endpoint model that takes sample messages from the dispatcher.
// Assumes the dispatcher's clock and reset; the bench reads its queue.
module endpoint_model (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    // Pacing controls from the bench
    input  wire logic                          stall_in,
    input  wire logic                          slow_in,
    // Message endpoint
    input  wire logic                          msg_valid_in,
    output logic                               msg_ready_out,
    input  wire adc_dispatch_pkg::sample_msg_t msg_in
);
    timeunit 1ns;
    timeprecision 1ps;

    adc_dispatch_pkg::sample_msg_t got[$];

    // A slow endpoint accepts on every other cycle only.
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            msg_ready_out <= 1'b0;
            got.delete();
        end else begin
            msg_ready_out <= !stall_in && !(slow_in && msg_ready_out);
            if (msg_valid_in && msg_ready_out) begin
                got.push_back(msg_in);
            end
        end
    end
endmodule : endpoint_model

// File: test/adc_sample_dispatch_test.sv
// Self-checking bench for the sample dispatcher.
// Assumes a converter answering four cycles after each start.
module adc_sample_dispatch_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic                          clk_in;
    logic                          sys_rst_in;
    logic                          trig;
    logic                          conv_start;
    logic [1:0]                    conv_pin;
    logic                          conv_done;
    logic [11:0]                   conv_result;
    logic [1:0]                    cnt;
    logic                          msg_valid;
    logic                          msg_ready;
    logic                          stall;
    logic                          slow;
    logic                          ce;
    adc_dispatch_pkg::acc_req_t    acc_req;
    adc_dispatch_pkg::acc_resp_t   acc_resp;
    adc_dispatch_pkg::sample_msg_t msg;
    int                            fails;
    int                            checked;

    adc_sample_dispatch i_dut (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .ce_in          (ce),
        .sample_trig_in (trig),
        .acc_req_in     (acc_req),
        .acc_resp_out   (acc_resp),
        .conv_start_out (conv_start),
        .conv_pin_out   (conv_pin),
        .conv_done_in   (conv_done),
        .conv_result_in (conv_result),
        .msg_valid_out  (msg_valid),
        .msg_ready_in   (msg_ready),
        .msg_out        (msg)
    );

    endpoint_model i_ep (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .stall_in      (stall),
        .slow_in       (slow),
        .msg_valid_in  (msg_valid),
        .msg_ready_out (msg_ready),
        .msg_in        (msg)
    );

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // ****************************************************************
    // Converter model
    // ****************************************************************
    // Outside a done pulse the result lines toggle so stale data is seen.
    always @(posedge clk_in) begin
        conv_done   <= 1'b0;
        conv_result <= ~conv_result;
        if (sys_rst_in) begin
            cnt <= 2'h0;
        end else if (conv_start) begin
            cnt <= 2'h3;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
            if (cnt == 2'h1) begin
                conv_done   <= 1'b1;
                conv_result <= 12'h5a0 | 12'(conv_pin);
            end
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // All accesses are whole 32-bit words.
    task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] r,
                       input logic [31:0] d,
                       output adc_dispatch_pkg::acc_resp_t resp);
        @(posedge clk_in);
        acc_req <= '{valid: 1'b1, write: w, periph: p, regnum: r, wdata: d};
        @(posedge clk_in);
        acc_req.valid <= 1'b0;
        @(posedge clk_in);
        resp = acc_resp;
    endtask : acc

    task automatic wr(input logic [7:0] r, input logic [31:0] d);
        adc_dispatch_pkg::acc_resp_t resp;
        acc(1'b1, adc_dispatch_pkg::PERIPH_ID, r, d, resp);
        check(resp.ok, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] r, input logic [31:0] exp);
        adc_dispatch_pkg::acc_resp_t resp;
        acc(1'b0, adc_dispatch_pkg::PERIPH_ID, r, 32'h0, resp);
        check({resp.done, resp.ok, resp.rdata}, {2'h3, exp});
    endtask : rd

    task automatic pulse_trig();
        @(posedge clk_in);
        trig <= 1'b1;
        repeat (4) @(posedge clk_in);
        trig <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask : pulse_trig

    task automatic wait_msgs(input int n);
        int i;
        for (i = 0; i < 3000 && i_ep.got.size() < n; i++) @(posedge clk_in);
        if (i_ep.got.size() < n) begin
            $display("[ERR] %0t messages did not arrive", $time);
            fails++;
            stop_test();
        end
    endtask : wait_msgs

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset_map();
        adc_dispatch_pkg::acc_resp_t resp;
        for (int p = 0; p < 4; p++) rd(8'(p * 4), 32'h0);
        rd(adc_dispatch_pkg::GEN_CTL_OFS, 32'h0);
        acc(1'b0, adc_dispatch_pkg::PERIPH_ID, 8'h10, 32'h0, resp);
        check({resp.done, resp.ok}, 2'h2);
        acc(1'b0, 8'h03, 8'h00, 32'h0, resp);
        check(resp.done, 1'b0);
        $display("test reset and map done");
    endtask : test_reset_map

    task automatic test_fields();
        for (int p = 0; p < 4; p++) begin
            wr(8'(p * 4), 32'hffff_fffe);
            rd(8'(p * 4), 32'hffff_ff00);
            wr(8'(p * 4), 32'h1234_56ff ^ 32'(p << 8));
            rd(8'(p * 4), 32'h1234_5601 ^ 32'(p << 8));
            wr(8'(p * 4), 32'h0);
        end
        $display("test fields done");
    endtask : test_fields

    task automatic test_round_robin();
        adc_dispatch_pkg::sample_msg_t exp;
        pulse_trig();
        check(i_ep.got.size(), 0);
        wr(adc_dispatch_pkg::PIN0_OFS, 32'h00aa_0001);
        wr(adc_dispatch_pkg::PIN2_OFS, 32'h00cc_0201);
        wr(adc_dispatch_pkg::GEN_CTL_OFS, 32'h1);
        slow <= 1'b1;
        for (int k = 0; k < 4; k++) pulse_trig();
        wait_msgs(4);
        for (int k = 0; k < 4; k++) begin
            exp.pin    = (k % 2 == 0) ? 2'h0 : 2'h2;
            exp.dest   = (k % 2 == 0) ? 24'h00aa_00 : 24'h00cc_02;
            exp.result = 12'h5a0 | 12'(exp.pin);
            check(i_ep.got[k], exp);
        end
        slow <= 1'b0;
        i_ep.got.delete();
        $display("test round robin done");
    endtask : test_round_robin

    task automatic test_fill();
        adc_dispatch_pkg::acc_resp_t resp;
        wr(adc_dispatch_pkg::PIN0_OFS, 32'h0);
        wr(adc_dispatch_pkg::PIN2_OFS, 32'h0);
        wr(adc_dispatch_pkg::PIN1_OFS, 32'h0077_0101);
        stall <= 1'b1;
        for (int k = 0; k < 20; k++) pulse_trig();
        acc(1'b0, adc_dispatch_pkg::PERIPH_ID, adc_dispatch_pkg::STATUS_OFS,
            32'h0, resp);
        check({resp.done, resp.ok, resp.rdata}, {2'h3, 32'h0000_0027});
        stall <= 1'b0;
        wait_msgs(17);
        repeat (40) @(posedge clk_in);
        check(msg_valid, 1'b0);
        check(i_ep.got.size(), 19);
        foreach (i_ep.got[k]) begin
            check(i_ep.got[k], {24'h0077_01, 2'h1, 12'h5a1});
        end
        $display("test fill and drain done");
    endtask : test_fill

    task automatic test_freeze();
        adc_dispatch_pkg::acc_resp_t resp;
        ce <= 1'b0;
        acc(1'b1, adc_dispatch_pkg::PERIPH_ID, adc_dispatch_pkg::PIN3_OFS,
            32'h0033_0301, resp);
        check(resp.done, 1'b0);
        ce <= 1'b1;
        rd(adc_dispatch_pkg::PIN3_OFS, 32'h0);
        $display("test freeze done");
    endtask : test_freeze

    initial begin
        fails      = 0;
        checked    = 0;
        sys_rst_in = 1'b1;
        trig       = 1'b0;
        stall      = 1'b0;
        slow       = 1'b0;
        ce         = 1'b1;
        acc_req    = '0;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        test_reset_map();
        test_fields();
        test_round_robin();
        test_fill();
        test_freeze();
        stop_test();
    end
endmodule : adc_sample_dispatch_test
